//--- design/pic_cfg.svh
// offsets, field positions, reset values and vectors of the interrupt block
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// register indices (nibble addresses); byte address is four times the index
`define PIC_IDX_R000 8'h00
`define PIC_IDX_R001 8'h01
`define PIC_IDX_R002 8'h02
`define PIC_IDX_R003 8'h03
`define PIC_IDX_R023 8'h23

// field positions: the mask of each source sits one bit above its flag
`define PIC_BIT_GLB_EN 0
`define PIC_BIT_WAKE_F 2
`define PIC_BIT_EXT_F 0
`define PIC_BIT_TMR_A_F 0
`define PIC_BIT_TMR_B_F 2
`define PIC_BIT_TMR_C_F 0
`define PIC_BIT_SER_F 2
`define PIC_BIT_ADC_F 2

// reset values
`define PIC_RST_GLB_EN 1'b0
`define PIC_RST_FLAGS 7'h00
`define PIC_RST_MASKS 7'h7f

// vector addresses
`define PIC_VEC_RESET 16'h0000
`define PIC_VEC_WAKE 16'h0002
`define PIC_VEC_EXT 16'h0004
`define PIC_VEC_TMR_A 16'h0008
`define PIC_VEC_TMR_B 16'h000a
`define PIC_VEC_TMR_C 16'h000c
`define PIC_VEC_SER_ADC 16'h000e

`endif

//--- design/pic_pkg.sv
// types shared by the interrupt block and its bench
package pic_pkg;

  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_FINISH,
    PIC_SAVE,
    PIC_JUMP
  } pic_state_t;

  // hardware event sources, each a one-cycle pulse
  typedef struct packed {
    logic [2:0] tmr_ovf;
    logic ser_done;
    logic ser_halt;
    logic adc_done;
  } pic_evt_t;

  // acceptance sequence towards the cpu sequencer
  typedef struct packed {
    logic finish;
    logic save;
    logic pc_load;
    logic [15:0] vector;
  } pic_seq_t;

endpackage : pic_pkg

//--- design/pic_top.sv
// priority interrupt controller with apb access to its control bits
//
// What this block does
// RQ1: seven sources: wake, ext, three timers, serial, adc
// RQ2: per-source flag, mask, vector; one global enable
// RQ3: serial and adc share vector 000e
// RQ4: control bits at nibble addresses 000-003, 023
// RQ5: software can never set a request flag
// RQ6: reset: enable, flags to 0; masks to 1
// RQ7: request is flag and not mask, gated enable
// RQ8: lowest priority number wins among pending
// RQ9: vectors reset 0000, wake 0002, ext 0004, a 0008
// RQ10: vectors b 000a, c 000c, serial/adc 000e
// RQ11: first cycle: cpu finishes current instruction
// RQ12: second cycle clears global enable
// RQ13: second, third cycles push carry, status, pc
// RQ14: third cycle loads pc with vector
// RQ15: vector slot should hold a long jump
// RQ16: handler clears its flag; hardware does not
// RQ17: return instruction sets enable; acceptance clears it
// RQ18: wake pin falling edge sets wake flag; the block ignores it while stop_mode_i is high
// RQ19: ext pin falling edge sets ext flag
// RQ20: timer overflow sets that timer's flag
// RQ21: serial done or halted sets serial flag
//
// The register offsets and the APB slave port are this design's own decisions.

`include "pic_cfg.svh"

module pic_top
  import pic_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt pins, active low; stop mode input, active high
  input wire logic wake_pin_n_i,
  input wire logic ext_irq_pin_n_i,
  input wire logic stop_mode_i,
  // peripheral events
  input wire pic_evt_t evt_i,
  // cpu sequencer
  input wire logic return_from_irq_instr_i,
  output pic_seq_t seq_o
);

  // ---------------------------------------------------------------
  // source map
  // ---------------------------------------------------------------
  localparam int NSRC = 7; // RQ1
  localparam logic [7:0] SRC_IDX [NSRC] = '{
    `PIC_IDX_R000, `PIC_IDX_R001, `PIC_IDX_R002, `PIC_IDX_R002,
    `PIC_IDX_R003, `PIC_IDX_R023, `PIC_IDX_R003
  };
  localparam int SRC_BIT [NSRC] = '{
    `PIC_BIT_WAKE_F, `PIC_BIT_EXT_F, `PIC_BIT_TMR_A_F, `PIC_BIT_TMR_B_F,
    `PIC_BIT_TMR_C_F, `PIC_BIT_SER_F, `PIC_BIT_ADC_F
  };
  // per-source reset values, one bit per flag or mask
  localparam logic [6:0] RST_FLAGS = `PIC_RST_FLAGS;
  localparam logic [6:0] RST_MASKS = `PIC_RST_MASKS;

  logic [6:0] req_flag_reg;
  logic [6:0] req_mask_reg;
  logic global_irq_enable_reg;
  logic wake_prev_reg;
  logic ext_prev_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  pic_state_t state_reg;
  pic_seq_t seq_reg;

  logic [6:0] evt;
  logic [6:0] pend;
  logic [6:0] sw_clr;
  logic [6:0] mask_wr;
  logic [15:0] sel_vec;
  logic start;
  logic acc;
  logic wr_en;
  logic hit;
  logic [7:0] idx;
  logic [3:0] rd_nib;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, so the
  // answer always comes from flops
  assign acc = psel_i && penable_i && !pready_reg;
  assign wr_en = psel_i && penable_i && pready_reg && pwrite_i;
  assign idx = paddr_i[9:2];

  always_comb begin
    hit = 1'b0;
    if (paddr_i[ADDR_W-1:10] == '0) begin
      hit = (idx == `PIC_IDX_R000) || (idx == `PIC_IDX_R001) ||
            (idx == `PIC_IDX_R002) || (idx == `PIC_IDX_R003) ||
            (idx == `PIC_IDX_R023); // RQ4
    end
  end

  // read nibble; reserved bits read as zero
  always_comb begin
    rd_nib = 4'h0;
    if (hit && idx == `PIC_IDX_R000) begin
      rd_nib[`PIC_BIT_GLB_EN] = global_irq_enable_reg;
    end
    for (int i = 0; i < NSRC; i++) begin
      if (hit && idx == SRC_IDX[i]) begin
        rd_nib[SRC_BIT[i]] = req_flag_reg[i]; // RQ4
        rd_nib[SRC_BIT[i] + 1] = req_mask_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= acc;
      pslverr_reg <= acc && !hit;
      if (acc && !pwrite_i) begin
        prdata_reg <= {28'h000_0000, rd_nib};
      end
    end
  end

  // ---------------------------------------------------------------
  // request flags and masks
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_prev_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      wake_prev_reg <= wake_pin_n_i;
      ext_prev_reg <= ext_irq_pin_n_i;
    end
  end

  // leaving stop mode by the wake pin does not set the flag
  assign evt[0] = wake_prev_reg && !wake_pin_n_i && !stop_mode_i; // RQ18
  assign evt[1] = ext_prev_reg && !ext_irq_pin_n_i; // RQ19
  assign evt[4:2] = evt_i.tmr_ovf; // RQ20
  assign evt[5] = evt_i.ser_done || evt_i.ser_halt; // RQ21
  assign evt[6] = evt_i.adc_done;

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    // writing 0 clears a flag, writing 1 leaves it alone
    assign sw_clr[g] = wr_en && hit && idx == SRC_IDX[g] &&
                       !pwdata_i[SRC_BIT[g]]; // RQ5
    assign mask_wr[g] = wr_en && hit && idx == SRC_IDX[g];

    // an event in the clearing cycle wins; acceptance never clears
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        req_flag_reg[g] <= RST_FLAGS[g]; // RQ6
      end else if (evt[g]) begin
        req_flag_reg[g] <= 1'b1; // RQ5
      end else if (sw_clr[g]) begin
        req_flag_reg[g] <= 1'b0; // RQ16
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        req_mask_reg[g] <= RST_MASKS[g]; // RQ6
      end else if (mask_wr[g]) begin
        req_mask_reg[g] <= pwdata_i[SRC_BIT[g] + 1]; // RQ2
      end
    end
  end

  assign pend = req_flag_reg & ~req_mask_reg; // RQ7

  // ---------------------------------------------------------------
  // global enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable_reg <= `PIC_RST_GLB_EN; // RQ6
    end else if (state_reg == PIC_SAVE) begin
      global_irq_enable_reg <= 1'b0; // RQ12
    end else if (return_from_irq_instr_i) begin
      global_irq_enable_reg <= 1'b1; // RQ17
    end else if (wr_en && hit && idx == `PIC_IDX_R000) begin
      global_irq_enable_reg <= pwdata_i[`PIC_BIT_GLB_EN]; // RQ2
    end
  end

  // ---------------------------------------------------------------
  // priority and vector
  // ---------------------------------------------------------------
  always_comb begin
    if (pend[0]) begin
      sel_vec = `PIC_VEC_WAKE; // RQ8 RQ9
    end else if (pend[1]) begin
      sel_vec = `PIC_VEC_EXT; // RQ9
    end else if (pend[2]) begin
      sel_vec = `PIC_VEC_TMR_A; // RQ9
    end else if (pend[3]) begin
      sel_vec = `PIC_VEC_TMR_B; // RQ10
    end else if (pend[4]) begin
      sel_vec = `PIC_VEC_TMR_C; // RQ10
    end else if (pend[5] || pend[6]) begin
      sel_vec = `PIC_VEC_SER_ADC; // RQ3 RQ10
    end else begin
      sel_vec = `PIC_VEC_RESET;
    end
  end

  assign start = state_reg == PIC_IDLE && global_irq_enable_reg &&
                 (pend != 7'h00); // RQ7

  // ---------------------------------------------------------------
  // acceptance sequence
  // ---------------------------------------------------------------
  // the vector is frozen at acceptance so a later, higher request
  // cannot redirect a sequence already under way
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= PIC_IDLE;
      seq_reg <= '0;
    end else begin
      case (state_reg)
        PIC_IDLE: begin
          seq_reg.save <= 1'b0;
          seq_reg.pc_load <= 1'b0;
          if (start) begin
            state_reg <= PIC_FINISH;
            seq_reg.finish <= 1'b1; // RQ11
            seq_reg.vector <= sel_vec;
          end
        end
        PIC_FINISH: begin
          state_reg <= PIC_SAVE;
          seq_reg.finish <= 1'b0;
          seq_reg.save <= 1'b1; // RQ13
        end
        PIC_SAVE: begin
          state_reg <= PIC_JUMP;
          seq_reg.pc_load <= 1'b1; // RQ14
        end
        PIC_JUMP: begin
          state_reg <= PIC_IDLE;
          seq_reg.save <= 1'b0;
          seq_reg.pc_load <= 1'b0;
        end
        default: begin
          state_reg <= PIC_IDLE;
          seq_reg <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign seq_o = seq_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_no_sw_set: assert property ( // RQ5
    ((req_flag_reg & ~$past(req_flag_reg)) & ~$past(evt)) == 7'h00
  ) else $error("request flag rose without a hardware event");

  chk_seq_order: assert property ( // RQ11
    start |=> seq_reg.finish && !seq_reg.save
      ##1 seq_reg.save && !seq_reg.pc_load && !seq_reg.finish
      ##1 seq_reg.save && seq_reg.pc_load
      ##1 !seq_reg.save && !seq_reg.pc_load
  ) else $error("acceptance sequence out of order");

  chk_enable_cleared: assert property ( // RQ12
    seq_reg.save && !seq_reg.pc_load |=> !global_irq_enable_reg
  ) else $error("global enable not cleared in second cycle");

  chk_vec_loaded: assert property ( // RQ14
    start |-> ##3 seq_reg.pc_load && seq_reg.vector == $past(sel_vec, 3)
  ) else $error("vector not loaded in third cycle");

  chk_start_gate: assert property ( // RQ7
    seq_reg.finish && !$past(seq_reg.finish) |->
      $past(global_irq_enable_reg) && $past(pend) != 7'h00
  ) else $error("sequence began without enabled request");

  chk_prio_wake: assert property ( // RQ8
    start && pend[0] |=> seq_reg.vector == `PIC_VEC_WAKE
  ) else $error("wake request not served first");

  chk_prio_shared: assert property ( // RQ3
    start && pend[4:0] == 5'h00 |=> seq_reg.vector == `PIC_VEC_SER_ADC
  ) else $error("serial or adc vector wrong");

  chk_prio_tmr_b: assert property ( // RQ10
    start && pend[3:0] == 4'h8 |=> seq_reg.vector == `PIC_VEC_TMR_B
  ) else $error("timer b vector wrong");

  chk_return_sets: assert property ( // RQ17
    return_from_irq_instr_i && state_reg != PIC_SAVE
      |=> global_irq_enable_reg
  ) else $error("return did not set global enable");

  chk_no_hw_clear: assert property ( // RQ16
    seq_reg.save && !$past(wr_en) |->
      (req_flag_reg & $past(req_flag_reg)) == $past(req_flag_reg)
  ) else $error("flag cleared by acceptance");

  chk_ext_edge: assert property ( // RQ19
    ext_prev_reg && !ext_irq_pin_n_i |=> req_flag_reg[1]
  ) else $error("ext falling edge lost");

  chk_wake_edge: assert property ( // RQ18
    wake_prev_reg && !wake_pin_n_i && !stop_mode_i |=> req_flag_reg[0]
  ) else $error("wake falling edge lost");

  chk_ser_set: assert property ( // RQ21
    evt_i.ser_done || evt_i.ser_halt |=> req_flag_reg[5]
  ) else $error("serial event lost");

  chk_apb_wait: assert property ( // RQ4
    psel_i && penable_i && !pready_reg |=> pready_reg
  ) else $error("apb access not answered in two cycles");

endmodule : pic_top

//--- testbench/pic_cpu_model.sv
// cpu sequencer and peripheral event model facing the interrupt block
module pic_cpu_model
  import pic_pkg::*;
(
  // clock
  input wire logic clk_i,
  // sequencer side
  input wire pic_seq_t seq_i,
  output logic ret_o,
  // event side
  output pic_evt_t evt_o,
  output logic wake_n_o,
  output logic ext_n_o
);
  logic [15:0] pc_reg;

  initial begin
    ret_o = 1'b0;
    evt_o = '0;
    wake_n_o = 1'b1;
    ext_n_o = 1'b1;
  end

  // each slot holds a long jump, so landing on the slot is enough here
  always_ff @(posedge clk_i) begin
    if (seq_i.pc_load) begin
      pc_reg <= seq_i.vector;
    end
  end

  task automatic fire(input pic_evt_t e);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask : fire

  // pin held low two samples so the edge cannot slip between edges
  task automatic pin_fall(input logic wake);
    wake_n_o <= ~wake;
    ext_n_o <= wake;
    repeat (2) @(posedge clk_i);
    wake_n_o <= 1'b1;
    ext_n_o <= 1'b1;
    @(posedge clk_i);
  endtask : pin_fall

  task automatic ret();
    ret_o <= 1'b1;
    @(posedge clk_i);
    ret_o <= 1'b0;
  endtask : ret
endmodule : pic_cpu_model

//--- testbench/pic_top_tb.sv
// self-checking bench for the priority interrupt controller
module pic_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pic_pkg::*;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stop_mode = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ret;
  logic wake_n;
  logic ext_n;
  pic_evt_t evt;
  pic_seq_t seq;
  logic [31:0] rd;
  logic err;
  logic [31:0] hits;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [11:0] reg_adr [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h08c};
  logic [3:0] reg_rst [5] = '{4'h8, 4'h2, 4'ha, 4'ha, 4'h8};
  logic [3:0] reg_flg [5] = '{4'h4, 4'h1, 4'h5, 4'h5, 4'h4};
  // sources in priority order; clear word keeps other flags (1 is no-op)
  logic [11:0] src_adr [7] = '{12'h000, 12'h004, 12'h008, 12'h008,
                               12'h00c, 12'h08c, 12'h00c};
  logic [3:0] src_clr [7] = '{4'h0, 4'h0, 4'h4, 4'h1, 4'h4, 4'h0, 4'h1};
  logic [15:0] src_vec [7] = '{16'h0002, 16'h0004, 16'h0008, 16'h000a,
                               16'h000c, 16'h000e, 16'h000e};

  always #2 clk_i = ~clk_i;

  pic_top u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .wake_pin_n_i(wake_n), .ext_irq_pin_n_i(ext_n),
    .stop_mode_i(stop_mode), .evt_i(evt),
    .return_from_irq_instr_i(ret), .seq_o(seq)
  );

  pic_cpu_model u_cpu (
    .clk_i(clk_i), .seq_i(seq), .ret_o(ret), .evt_o(evt),
    .wake_n_o(wake_n), .ext_n_o(ext_n)
  );

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [11:0] a, input logic [3:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, {28'h0, exp});
  endtask : rchk

  task automatic accept(input logic [15:0] v);
    int n;
    n = 0;
    while (seq.finish !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk({29'h0, seq.finish, seq.save, seq.pc_load}, 32'h4);
    chk({16'h0, seq.vector}, {16'h0, v});
    @(posedge clk_i);
    chk({29'h0, seq.finish, seq.save, seq.pc_load}, 32'h2);
    @(posedge clk_i);
    chk({29'h0, seq.finish, seq.save, seq.pc_load}, 32'h3);
    @(posedge clk_i);
    chk({29'h0, seq.finish, seq.save, seq.pc_load}, 32'h0);
    chk({16'h0, u_cpu.pc_reg}, {16'h0, v});
  endtask : accept

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // a hung handshake ends the run well past the expected few hundred
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) rchk(reg_adr[i], reg_rst[i]);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h5);
    rchk(12'h008, 4'h0);
    apb(1'b1, 12'h008, 32'ha);
    stop_mode <= 1'b1;
    u_cpu.pin_fall(1'b1);
    stop_mode <= 1'b0;
    rchk(12'h000, 4'h8);
    u_cpu.fire(6'b111101);
    u_cpu.pin_fall(1'b1);
    u_cpu.pin_fall(1'b0);
    for (int i = 0; i < 5; i++) begin
      rchk(reg_adr[i], reg_rst[i] | reg_flg[i]);
    end
    apb(1'b1, 12'h08c, 32'h8);
    rchk(12'h08c, 4'h8);
    u_cpu.fire(6'b000010);
    rchk(12'h08c, 4'hc);
    apb(1'b1, 12'h000, 32'hd);
    hits = '0;
    repeat (10) begin
      @(posedge clk_i);
      hits = hits + {31'h0, seq.finish};
    end
    chk(hits, 32'h0);
    apb(1'b1, 12'h000, 32'hc);
    for (int i = 1; i < 5; i++) begin
      apb(1'b1, reg_adr[i], {28'h0, reg_flg[i]});
    end
    apb(1'b1, 12'h000, 32'h5);
    for (int i = 0; i < 7; i++) begin
      accept(src_vec[i]);
      if (i == 0) rchk(12'h000, 4'h4);
      apb(1'b1, src_adr[i], {28'h0, src_clr[i]});
      u_cpu.ret();
    end
    // a second reset mid-run must force masks back and clear the enable
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) rchk(reg_adr[i], reg_rst[i]);
    complete_run();
  end
endmodule : pic_top_tb
